// ==== hw/rwsi_params.svh ====
/*
  reset and wake-up init values, vectors and field positions for the
  reset/wake sequencer. assumes inclusion by the rwsi package only.
*/
`ifndef RWSI_PARAMS_SVH
`define RWSI_PARAMS_SVH
`define RWSI_PC_W        21
`define RWSI_SP_W        5
`define RWSI_STK_DEPTH   31
`define RWSI_VEC_HIGH    21'h000008
`define RWSI_VEC_LOW     21'h000018
`define RWSI_PC_RST      21'h000000
`define RWSI_PC_STEP     21'h000002
`define RWSI_SP_RST      5'h00
`define RWSI_PA_BIT      6
`define RWSI_INTCON_POR  8'h00
`define RWSI_INTCON3_RST 8'hc0
`define RWSI_PIR_RST     8'h00
`define RWSI_STKFUL_BIT  7
`define RWSI_STKUNF_BIT  6
`endif

// ==== hw/rwsi_pkg.sv ====
/*
  types for the reset/wake sequencer.
  assumes rwsi_params.svh is on the include path.
*/
`include "rwsi_params.svh"
package rwsi_pkg;
  typedef logic [`RWSI_PC_W-1:0] rwsi_pc_t;
  typedef logic [`RWSI_SP_W-1:0] rwsi_sp_t;
  typedef enum logic [1:0] {
    RWSI_IDLE  = 2'b00,
    RWSI_SLEEP = 2'b01,
    RWSI_PUSH  = 2'b10
  } rwsi_state_e;
  typedef enum logic [1:0] {
    RWSI_EV_NONE  = 2'b00,
    RWSI_EV_POR   = 2'b01,
    RWSI_EV_RST   = 2'b10,
    RWSI_EV_WAKE  = 2'b11
  } rwsi_event_e;
endpackage

// ==== hw/rwsi_event_if.sv ====
/*
  carries the decoded init event from the classifier to the core block.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface rwsi_event_if;
  import rwsi_pkg::*;
  rwsi_event_e ev;
  logic        wake_irq;
  logic        wake_high;
  modport src (output ev, output wake_irq, output wake_high);
  modport dst (input ev, input wake_irq, input wake_high);
endinterface

// ==== hw/rwsi_classify.sv ====
/*
  classifies reset sources and wake causes into one init event.
  assumes all inputs already synchronised; sleep flag from the core.
*/
`timescale 1ns/1ps
module rwsi_classify
  import rwsi_pkg::*;
(
  input  wire logic  por_req,
  input  wire logic  bor_req,
  input  wire logic  pin_rst,
  input  wire logic  wdt_tmo,
  input  wire logic  rst_instr,
  input  wire logic  stk_rst,
  input  wire logic  asleep,
  input  wire logic  irq_high,
  input  wire logic  irq_low,
  rwsi_event_if.src  evo
);
  always_comb begin
    evo.wake_irq  = 1'b0;
    evo.wake_high = irq_high;
    if (por_req || bor_req) begin
      evo.ev = RWSI_EV_POR; // see R1
    end else if (pin_rst || rst_instr || stk_rst ||
                 (wdt_tmo && !asleep)) begin
      evo.ev = RWSI_EV_RST; // see R1
    end else if (asleep && (wdt_tmo || irq_high || irq_low)) begin
      evo.ev       = RWSI_EV_WAKE; // see R1
      evo.wake_irq = irq_high || irq_low;
    end else begin
      evo.ev = RWSI_EV_NONE;
    end
  end
endmodule

// ==== hw/rwsi_top.sv ====
/*
  reset and wake-up state initialisation: program counter, return stack,
  irq flag registers and port a bit 6 gating per oscillator mode.
  assumes one 10 mhz clock; raw reset sources and irq lines are async.
*/
// Contract
// R1 - distinct init values for por/bor, other resets, and wake-up
// R2 - irq wake with a global enable pushes pc into the stack top bytes
// R3 - irq wake with a global enable advances the stack pointer
// R4 - irq wake with a global enable loads pc with vector 0008h or 0018h
// R5 - wake-up sets at least one irq control or request flag
// R6 - port a bit 6 and its latch/direction live only in freeing osc modes
// R7 - bits marked unchanged keep their value through the event
`timescale 1ns/1ps
module rwsi_top
  import rwsi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        por_req,
  input  wire logic        bor_req,
  input  wire logic        external_reset_pin,
  input  wire logic        watchdog_timer,
  input  wire logic        rst_instr,
  input  wire logic        stk_rst,
  input  wire logic        sleep_req,
  input  wire logic        irq_high_req,
  input  wire logic        irq_low_req,
  input  wire logic [7:0]  periph_irq_src,
  input  wire logic        high_prio_global_irq_enable,
  input  wire logic        low_prio_global_irq_enable,
  input  wire logic        step,
  input  wire logic        osc_frees_pin,
  input  wire logic        latch_wr,
  input  wire logic        latch_wr_val,
  input  wire logic        dir_wr,
  input  wire logic        dir_wr_val,
  input  wire logic        pin_in,
  output logic [20:0]      pc,
  output logic [4:0]       stack_pointer_reg,
  output logic [4:0]       stack_top_upper,
  output logic [7:0]       stack_top_high,
  output logic [7:0]       stack_top_low,
  output logic [7:0]       irq_control_regs,
  output logic [7:0]       periph_irq_request_regs,
  output logic             asleep,
  output logic             port_a_pins,
  output logic             port_a_latch,
  output logic             port_a_direction,
  output logic [1:0]       last_event
);
  typedef struct packed {
    rwsi_state_e st;
    rwsi_pc_t    pc;
    rwsi_sp_t    sp;
    rwsi_pc_t    tos;
    logic [7:0]  intcon;
    logic [7:0]  pir;
    logic        lat;
    logic        dir;
    logic        pin;
    logic [1:0]  ev;
    logic [9:0]  s1;
    logic [9:0]  s2;
    logic [7:0]  p1;
    logic [7:0]  p2;
  } rwsi_reg_s;

  rwsi_reg_s   r_r;
  rwsi_reg_s   r_nxt;
  rwsi_pc_t    stack_mem [`RWSI_STK_DEPTH];
  logic        push_en;
  rwsi_event_if evi();

  // s2 bits: 0 por 1 bor 2 pin 3 wdt 4-5 tied low (instr, stk go in direct) 6 hi 7 lo 8 sleep 9 pa6
  rwsi_classify u_cls (
    .por_req   (r_r.s2[0]),
    .bor_req   (r_r.s2[1]),
    .pin_rst   (r_r.s2[2]),
    .wdt_tmo   (r_r.s2[3]),
    .rst_instr (rst_instr),
    .stk_rst   (stk_rst),
    .asleep    (r_r.st == RWSI_SLEEP),
    .irq_high  (r_r.s2[6]),
    .irq_low   (r_r.s2[7]),
    .evo       (evi)
  );

  function automatic logic gie_on(input logic hi, input logic lo);
    gie_on = hi || lo;
  endfunction

  always_comb begin
    r_nxt    = r_r;
    push_en  = 1'b0;
    r_nxt.s1 = {pin_in, sleep_req, irq_low_req, irq_high_req, 1'b0,
                1'b0, watchdog_timer, external_reset_pin, bor_req, por_req};
    r_nxt.s2 = r_r.s1;
    r_nxt.p1 = periph_irq_src;
    r_nxt.p2 = r_r.p1;
    // last event stands until the next one
    if (evi.ev != RWSI_EV_NONE) begin
      r_nxt.ev = evi.ev; // see R1
    end
    // irq request flags latch while running; set wins over nothing else
    r_nxt.pir = r_r.pir | r_r.p2;
    case (evi.ev)
      RWSI_EV_POR: begin
        r_nxt.st     = RWSI_IDLE; // see R1
        r_nxt.pc     = `RWSI_PC_RST;
        r_nxt.sp     = `RWSI_SP_RST;
        r_nxt.tos    = `RWSI_PC_RST;
        r_nxt.intcon = `RWSI_INTCON_POR;
        r_nxt.pir    = `RWSI_PIR_RST;
        r_nxt.lat    = 1'b0;
        r_nxt.dir    = 1'b1;
      end
      RWSI_EV_RST: begin
        r_nxt.st     = RWSI_IDLE; // see R1
        r_nxt.pc     = `RWSI_PC_RST;
        r_nxt.tos    = `RWSI_PC_RST;
        // all stack pointer bits clear, no overflow/underflow flags kept, see R7
        r_nxt.sp     = `RWSI_SP_RST;
        r_nxt.intcon = {r_r.intcon[7:1] & 7'h00, r_r.intcon[0]}; // see R7
        r_nxt.pir    = `RWSI_PIR_RST;
        r_nxt.dir    = 1'b1;
      end
      RWSI_EV_WAKE: begin
        r_nxt.st = RWSI_IDLE;
        r_nxt.pc = r_r.pc + `RWSI_PC_STEP; // see R7
        if (evi.wake_irq) begin
          // cause recorded in the flag registers, see R5
          r_nxt.intcon[1] = 1'b1;
          r_nxt.pir       = r_r.pir | r_r.p2;
          if (gie_on(high_prio_global_irq_enable,
                     low_prio_global_irq_enable)) begin
            r_nxt.st = RWSI_PUSH;
          end
        end else begin
          r_nxt.intcon[2] = 1'b1; // see R5
        end
      end
      default: begin
        case (r_r.st)
          RWSI_IDLE: begin
            if (r_r.s2[8]) begin
              r_nxt.st = RWSI_SLEEP;
            end else if (step) begin
              r_nxt.pc = r_r.pc + `RWSI_PC_STEP;
            end
          end
          RWSI_SLEEP: begin
            r_nxt.st = RWSI_SLEEP; // pc, stack and intcon held; request flags and port a still update, see R7
          end
          RWSI_PUSH: begin
            push_en  = 1'b1;
            r_nxt.tos = r_r.pc; // see R2
            r_nxt.sp = r_r.sp + 5'h01; // see R3
            r_nxt.pc = evi.wake_high ? `RWSI_VEC_HIGH
                                     : `RWSI_VEC_LOW; // see R4
            r_nxt.st = RWSI_IDLE;
          end
          default: begin
            r_nxt.st = RWSI_IDLE;
          end
        endcase
      end
    endcase
    // port a bit 6 exists only in freeing osc modes, see R6
    if (osc_frees_pin) begin
      if (latch_wr) begin
        r_nxt.lat = latch_wr_val;
      end
      if (dir_wr) begin
        r_nxt.dir = dir_wr_val;
      end
      r_nxt.pin = r_r.s2[9];
    end else begin
      r_nxt.lat = 1'b0;
      r_nxt.dir = 1'b0;
      r_nxt.pin = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push_en && r_r.sp < 5'(`RWSI_STK_DEPTH)) begin
      stack_mem[r_r.sp] <= r_r.pc; // see R2
    end
  end

  assign pc                      = r_r.pc;
  assign stack_pointer_reg       = r_r.sp;
  assign stack_top_upper         = r_r.tos[20:16];
  assign stack_top_high          = r_r.tos[15:8];
  assign stack_top_low           = r_r.tos[7:0];
  assign irq_control_regs        = r_r.intcon;
  assign periph_irq_request_regs = r_r.pir;
  assign asleep                  = (r_r.st == RWSI_SLEEP);
  assign port_a_pins             = r_r.pin;
  assign port_a_latch            = r_r.lat;
  assign port_a_direction        = r_r.dir;
  assign last_event              = r_r.ev;
endmodule

// ==== testbench/rwsi_top_assertions.sv ====
/* checker for rwsi_top: init values, wake push, port a gate.
   assumes a bind to rwsi_top, one clock, sync low reset. */
`timescale 1ns/1ps
module rwsi_top_assertions
  import rwsi_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        high_prio_global_irq_enable,
  input wire logic        low_prio_global_irq_enable,
  input wire logic        osc_frees_pin,
  input wire logic [20:0] pc,
  input wire logic [4:0]  stack_pointer_reg,
  input wire logic [4:0]  stack_top_upper,
  input wire logic [7:0]  stack_top_high,
  input wire logic [7:0]  stack_top_low,
  input wire logic [7:0]  irq_control_regs,
  input wire logic [7:0]  periph_irq_request_regs,
  input wire logic        asleep,
  input wire logic        port_a_pins,
  input wire logic        port_a_latch,
  input wire logic        port_a_direction,
  input wire logic [1:0]  last_event
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_wake;
    $fell(asleep) && last_event == 2'h3;
  endsequence
  sequence s_push;
    s_wake ##0 (irq_control_regs[1] &&
      (high_prio_global_irq_enable || low_prio_global_irq_enable));
  endsequence
  chk_wake_pc: assert property (s_wake |-> pc == $past(pc) + 21'h2)
    else $error("wake pc not advanced");
  chk_wake_flag: assert property (s_wake |-> |irq_control_regs[2:1])
    else $error("wake cause flag missing");
  chk_pir_kept: assert property (s_wake |-> (periph_irq_request_regs &
    $past(periph_irq_request_regs)) == $past(periph_irq_request_regs))
    else $error("request flags lost on wake");
  chk_push_tos: assert property (s_push |=>
    {stack_top_upper, stack_top_high, stack_top_low} == $past(pc))
    else $error("stack top not loaded with pc");
  chk_push_sp: assert property (s_push |=>
    stack_pointer_reg == $past(stack_pointer_reg) + 5'h1)
    else $error("stack pointer not advanced");
  chk_push_vec: assert property (s_push |=> pc inside {21'h8, 21'h18})
    else $error("pc not at an irq vector");
  chk_por_init: assert property ($rose(last_event == 2'h1) |->
    pc == 21'h0 && irq_control_regs == 8'h00 && stack_pointer_reg == 5'h0)
    else $error("power-on values wrong");
  chk_rst_init: assert property ($rose(last_event == 2'h2) |->
    pc == 21'h0 && irq_control_regs[7:1] == 7'h00 &&
    periph_irq_request_regs == 8'h00)
    else $error("reset values wrong");
  chk_port_gate: assert property (!osc_frees_pin ##1 !osc_frees_pin |->
    {port_a_pins, port_a_latch, port_a_direction} == 3'h0)
    else $error("port a bit 6 not gated");
endmodule
bind rwsi_top rwsi_top_assertions i_chk (.*);

// ==== testbench/test_reset_wake_state_init.sv ====
/* testbench for rwsi_top: resets, wakes, push, port a gate.
   assumes the rwsi package and the checker are compiled first. */
`timescale 1ns/1ps
module test_reset_wake_state_init
  import rwsi_pkg::*;
;
  logic ref_clk = 0, nrst = 0, sleep_req = 0, irq_high_req = 0;
  logic irq_low_req = 0, step = 0, osc_frees_pin = 0, pin_in = 0;
  logic latch_wr = 0, latch_wr_val = 0, dir_wr = 0, dir_wr_val = 0;
  logic high_prio_global_irq_enable = 0, low_prio_global_irq_enable = 0;
  logic look = 0;
  logic [5:0] src = 6'h00;
  logic [7:0] periph_irq_src = 8'h00, p;
  logic [20:0] pc, e;
  logic [4:0] stack_pointer_reg, stack_top_upper;
  logic [7:0] stack_top_high, stack_top_low;
  logic [7:0] irq_control_regs, periph_irq_request_regs;
  logic asleep, port_a_pins, port_a_latch, port_a_direction;
  logic [1:0] last_event;
  logic [68:0] q[$];
  int err_count = 0, checks = 0, n;
  wire por_req = src[5], bor_req = src[4], external_reset_pin = src[3];
  wire watchdog_timer = src[2], rst_instr = src[1], stk_rst = src[0];
  wire [68:0] snap = {pc, stack_pointer_reg, stack_top_upper,
    stack_top_high, stack_top_low, irq_control_regs,
    periph_irq_request_regs, asleep, port_a_pins, port_a_latch,
    port_a_direction, last_event};
  rwsi_top i_dut (.*);
  always #50 ref_clk = ~ref_clk;
  task automatic go(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [68:0] seen, input logic [68:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t state %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic note(input logic [20:0] epc, input logic [4:0] esp,
    input logic [20:0] etos, input logic [7:0] eic, input logic [7:0] epir,
    input logic [2:0] epa, input logic [1:0] ev);
    q.push_back({epc, esp, etos, eic, epir, 1'b0, epa, ev});
    look <= 1'b1;
    @(negedge ref_clk) look <= 1'b0;
  endtask
  task automatic pulse(input logic [5:0] s);
    src = s;
    go(1);
    src = 6'h00;
    go(7);
  endtask
  task automatic stp(input int c);
    repeat (c) begin
      step = 1;
      go(1);
      step = 0;
      go(1);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(negedge ref_clk) if (look) chk(snap, q.pop_front());
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    void'($urandom(62815));
    go(8);
    nrst = 1;
    go(2);
    for (int i = 0; i < 6; i++) begin
      stp(1);
      pulse(6'h01 << i);
      note('0, '0, '0, '0, '0, '0, i > 3 ? 2'h1 : 2'h2);
    end
    n = $urandom_range(5, 1);
    p = 8'($urandom);
    periph_irq_src = p;
    stp(n);
    periph_irq_src = 8'h00;
    sleep_req = 1;
    go(5);
    sleep_req = 0;
    pulse(6'h04);
    note(21'(2 * n + 2), '0, '0, 8'h04, p, '0, 2'h3);
    pulse(6'h02);
    note('0, '0, '0, '0, '0, '0, 2'h2);
    osc_frees_pin = 1;
    pin_in = 1;
    {latch_wr, latch_wr_val, dir_wr, dir_wr_val} = 4'he;
    go(1);
    {latch_wr, dir_wr} = 2'h0;
    go(3);
    note('0, '0, '0, '0, '0, 3'h6, 2'h2);
    osc_frees_pin = 0;
    go(1);
    latch_wr = 1;
    go(1);
    latch_wr = 0;
    go(2);
    note('0, '0, '0, '0, '0, '0, 2'h2);
    e = '0;
    for (int i = 0; i < 2; i++) begin
      n = $urandom_range(4, 1);
      high_prio_global_irq_enable = (i == 0);
      low_prio_global_irq_enable = (i == 1);
      stp(n);
      sleep_req = 1;
      go(5);
      sleep_req = 0;
      if (i == 0) irq_high_req = 1;
      else irq_low_req = 1;
      go(6);
      {irq_high_req, irq_low_req} = 2'h0;
      e = e + 21'(2 * n + 2);
      note(i ? 21'h18 : 21'h08, 5'(i + 1), e, 8'h02, '0, '0, 2'h3);
      e = i ? 21'h18 : 21'h08;
    end
    nrst = 0;
    go(2);
    nrst = 1;
    go(1);
    note('0, '0, '0, '0, '0, '0, 2'h0);
    go(2);
    results();
  end
endmodule
